/* File: rtl/vasd_decoder.sv */
`include "vasd_params.svh"

`default_nettype none

module vasd_decoder #(
   parameter int PAGE_SHIFT_64 = `VASD_A64_PAGE_SHIFT,
   parameter logic [31:0] EXC_ENTRY = `VASD_EXC_ENTRY_DEFAULT
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire vasd_pkg::vasd_req_s req_in,
   output var vasd_pkg::vasd_resp_s resp_out,
   output var logic [63:0] bad_vaddr_out,
   output var logic [63:0] exc_vector_out
);
   import vasd_pkg::*;

   // Page field is 28 bits; a shift below 12 leaves page bits beyond it
   if (PAGE_SHIFT_64 < 12)
   begin
      $error("vasd_decoder: PAGE_SHIFT_64 below 12 overflows the page");
   end

   // Offset field is 16 bits; a shift above 16 would truncate offsets
   if (PAGE_SHIFT_64 > 16)
   begin
      $error("vasd_decoder: PAGE_SHIFT_64 above 16 overflows the offset");
   end

   // Handler entry must sit in the cached unmapped segment (top bits 100)
   if (EXC_ENTRY[31:29] != 3'b100)
   begin
      $error("vasd_decoder: EXC_ENTRY outside cached segment");
   end

   // Handler entry as a 64-bit kernel address, sign-extended
   localparam logic [63:0] EXC_VECTOR64 = {{32{EXC_ENTRY[31]}}, EXC_ENTRY};

   // All registered state of the block
   vasd_state_s state;
   vasd_state_s next_state;

   // Page offset mask for 64-bit pages; 17 bits so shift 16 fits
   logic [16:0] ofs_mask64;
   assign ofs_mask64 = (17'h1 << PAGE_SHIFT_64) - 17'h1;

   // Working values of the decode
   logic [63:0] ea;
   logic [39:0] shifted64;
   logic rsv64_clear;
   logic phys_rsv_clear;
   logic [2:0] cache_alg;
   logic alg_uncached;

   // Effective address formation; done once so that every branch
   // below decodes the same view of the address
   always_comb
   begin
      if (req_in.mode64 && req_in.addr32_op)
      begin
         // 32-bit operand fills the top half from its sign bit
         ea = {{32{req_in.vaddr[31]}}, req_in.vaddr[31:0]};
      end
      else if (!req_in.mode64)
      begin
         // Upper half is ignored in 32-bit mode
         ea = {32'h0, req_in.vaddr[31:0]};
      end
      else
      begin
         ea = req_in.vaddr;
      end
   end

   // Field extraction shared by the 64-bit branches
   assign shifted64 = ea[39:0] >> PAGE_SHIFT_64;
   assign rsv64_clear =
      (ea[`VASD_A64_RSV_HI:`VASD_A64_RSV_LO] == 22'h0);
   assign phys_rsv_clear =
      (ea[`VASD_A64_PHYS_RSV_HI:`VASD_A64_RSV_LO] == 18'h0);
   assign cache_alg = ea[`VASD_A64_ALG_HI:`VASD_A64_ALG_LO];

   // Both uncached algorithms skip the cache; every other code caches
   assign alg_uncached = (cache_alg == `VASD_ALG_UNCACHED) ||
      (cache_alg == `VASD_ALG_UNC_ACCEL);

   // Decode of one request into the next answer
   always_comb
   begin
      next_state = state;
      // Defaults give a clean answer: no segment, no fault, no fields
      next_state.exc_vector = EXC_VECTOR64;
      next_state.resp.valid = req_in.valid;
      next_state.resp.kind = req_in.kind;
      next_state.resp.eff_addr = ea;
      next_state.resp.segment = VASD_SEG_NONE;
      next_state.resp.mapped = 1'b0;
      next_state.resp.cached = 1'b0;
      next_state.resp.fault = 1'b0;
      next_state.resp.cause = VASD_CAUSE_NONE;
      next_state.resp.virtual_page_number = 28'h0;
      next_state.resp.page_offset = 16'h0;
      next_state.resp.paddr = 40'h0;

      if (!req_in.mode64)
      begin
         // 32-bit mode: offset is the low 12 bits except on a privilege fault
         next_state.resp.page_offset = {4'h0, ea[11:0]};
         if (!ea[`VASD_A32_SIGN])
         begin
            // User segment: no unmapped path exists
            next_state.resp.segment = VASD_SEG_USER;
            next_state.resp.mapped = 1'b1;
            next_state.resp.cached = 1'b1;
            next_state.resp.virtual_page_number =
               {9'h0, ea[30:`VASD_A32_PAGE_SHIFT]};
         end
         else if (req_in.user_mode)
         begin
            // Kernel half touched from user mode
            next_state.resp.fault = 1'b1;
            next_state.resp.cause = VASD_CAUSE_PRIVILEGE;
            next_state.resp.page_offset = 16'h0;
         end
         else if (ea[`VASD_A32_KMAP])
         begin
            // Kernel mapped: 18-bit page, kernel mode only
            next_state.resp.segment = VASD_SEG_KERNEL_MAPPED;
            next_state.resp.mapped = 1'b1;
            next_state.resp.cached = 1'b1;
            next_state.resp.virtual_page_number =
               {10'h0, ea[29:`VASD_A32_PAGE_SHIFT]};
         end
         else if (!ea[`VASD_A32_UNC])
         begin
            // Physical address used only when the cache misses
            next_state.resp.segment = VASD_SEG_CACHED_UNMAPPED;
            next_state.resp.cached = 1'b1;
            next_state.resp.paddr = {11'h0, ea[28:0]};
         end
         else
         begin
            // Device registers must never be cached
            next_state.resp.segment = VASD_SEG_UNCACHED_UNMAPPED;
            next_state.resp.paddr = {11'h0, ea[28:0]};
         end
      end
      else
      begin
         case (ea[`VASD_A64_SEG_HI:`VASD_A64_SEG_LO])
            // 00: user process space, any mode
            `VASD_SEL64_USER:
            begin
               // Clear 61:40 keeps the address inside the low 1 TB (bits 39:0);
               // this is what limits users to the first 1 TB of the space
               if (!rsv64_clear)
               begin
                  next_state.resp.fault = 1'b1;
                  next_state.resp.cause = VASD_CAUSE_RESERVED_BITS;
               end
               else
               begin
                  next_state.resp.segment = VASD_SEG_USER;
                  next_state.resp.mapped = 1'b1;
                  next_state.resp.cached = 1'b1;
                  next_state.resp.virtual_page_number =
                     shifted64[27:0];
                  next_state.resp.page_offset =
                     ea[15:0] & ofs_mask64[15:0];
               end
            end

            // 11: kernel virtual space, mapped and cached
            `VASD_SEL64_KMAP:
            begin
               // Privilege is judged before the middle bits
               if (req_in.user_mode)
               begin
                  next_state.resp.fault = 1'b1;
                  next_state.resp.cause = VASD_CAUSE_PRIVILEGE;
               end
               else if (!rsv64_clear)
               begin
                  // Also catches sign-extended 32-bit kernel addresses
                  next_state.resp.fault = 1'b1;
                  next_state.resp.cause = VASD_CAUSE_RESERVED_BITS;
               end
               else
               begin
                  // Same page split as the user segment
                  next_state.resp.segment = VASD_SEG_KERNEL_MAPPED;
                  next_state.resp.mapped = 1'b1;
                  next_state.resp.cached = 1'b1;
                  next_state.resp.virtual_page_number =
                     shifted64[27:0];
                  next_state.resp.page_offset =
                     ea[15:0] & ofs_mask64[15:0];
               end
            end

            // 10: physical window, kernel only and never translated
            `VASD_SEL64_PHYS:
            begin
               // No user access to the window, whatever the algorithm
               if (req_in.user_mode)
               begin
                  next_state.resp.fault = 1'b1;
                  next_state.resp.cause = VASD_CAUSE_PRIVILEGE;
               end
               else if (!phys_rsv_clear)
               begin
                  next_state.resp.fault = 1'b1;
                  next_state.resp.cause = VASD_CAUSE_RESERVED_BITS;
               end
               else
               begin
                  // Qualifier bit 58 is ignored and not passed on; bit 57 must be clear
                  next_state.resp.segment = VASD_SEG_PHYS_WINDOW;
                  next_state.resp.cached = !alg_uncached;
                  next_state.resp.paddr = ea[39:0];
               end
            end

            // 01: supervisor space, left undefined
            default:
            begin
               // Supervisor space is unused here, so it is undefined
               next_state.resp.fault = 1'b1;
               next_state.resp.cause = VASD_CAUSE_UNDEFINED;
            end
         endcase
      end

      // Refused accesses never reach translation or the bus; cleared
      // here as well so that no branch can leak a field with a fault
      if (next_state.resp.fault)
      begin
         next_state.resp.segment = VASD_SEG_NONE;
         next_state.resp.mapped = 1'b0;
         next_state.resp.cached = 1'b0;
         next_state.resp.virtual_page_number = 28'h0;
         next_state.resp.page_offset = 16'h0;
         next_state.resp.paddr = 40'h0;
      end

      // Idle cycles carry no answer; the other fields stay decoded,
      // which costs nothing and shows where an idle address points
      if (!req_in.valid)
      begin
         next_state.resp.fault = 1'b0;
         next_state.resp.cause = VASD_CAUSE_NONE;
      end

      // Faulting address held for the exception handler
      // Only the latest fault is kept; a later one overwrites it
      if (req_in.valid && next_state.resp.fault)
      begin
         next_state.bad_vaddr = ea;
      end
   end

   // State register; synchronous reset to a clean idle answer
   // The vector reloads too, as it is only ever a constant
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state.resp <= '0;
         state.bad_vaddr <= 64'h0;
         state.exc_vector <= EXC_VECTOR64;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Outputs come straight from the state flops
   // so every consumer sees a full clock of settled timing
   assign resp_out = state.resp;
   assign bad_vaddr_out = state.bad_vaddr;
   assign exc_vector_out = state.exc_vector;

endmodule

`default_nettype wire

/* File: rtl/vasd_params.svh */
`ifndef VASD_PARAMS_SVH
`define VASD_PARAMS_SVH

// Address and field widths
`define VASD_VA_W 64
`define VASD_VPN_W 28
`define VASD_OFS_W 16
`define VASD_PA_W 40

// 32-bit mode field positions
`define VASD_A32_SIGN 31
`define VASD_A32_KMAP 30
`define VASD_A32_UNC 29
`define VASD_A32_PAGE_SHIFT 12

// 64-bit mode field positions
`define VASD_A64_SEG_HI 63
`define VASD_A64_SEG_LO 62
`define VASD_A64_RSV_HI 61
`define VASD_A64_RSV_LO 40
`define VASD_A64_PHYS_RSV_HI 57
`define VASD_A64_ALG_HI 61
`define VASD_A64_ALG_LO 59
`define VASD_A64_PAGE_SHIFT 14
`define VASD_A64_PAGE_KB 16
`define VASD_A64_USER_TB 16

// Segment selector and cache algorithm codes
`define VASD_SEL64_USER 2'b00
`define VASD_SEL64_PHYS 2'b10
`define VASD_SEL64_KMAP 2'b11
`define VASD_ALG_UNCACHED 3'b010
`define VASD_ALG_UNC_ACCEL 3'b111

// Default exception entry (low 32 bits)
`define VASD_EXC_ENTRY_DEFAULT 32'h8000_0000

`endif

/* File: rtl/vasd_pkg.sv */
`default_nettype none

package vasd_pkg;

   // Segment that an address falls in
   typedef enum logic [2:0] {
      VASD_SEG_NONE,
      VASD_SEG_USER,
      VASD_SEG_KERNEL_MAPPED,
      VASD_SEG_CACHED_UNMAPPED,
      VASD_SEG_UNCACHED_UNMAPPED,
      VASD_SEG_PHYS_WINDOW
   } vasd_seg_e;

   // Why an access was refused
   typedef enum logic [1:0] {
      VASD_CAUSE_NONE,
      VASD_CAUSE_PRIVILEGE,
      VASD_CAUSE_UNDEFINED,
      VASD_CAUSE_RESERVED_BITS
   } vasd_cause_e;

   typedef enum logic [1:0] {
      VASD_KIND_FETCH,
      VASD_KIND_LOAD,
      VASD_KIND_STORE
   } vasd_kind_e;

   typedef struct packed {
      logic valid;
      logic [63:0] vaddr;
      logic mode64;
      logic user_mode;
      logic addr32_op;
      vasd_kind_e kind;
   } vasd_req_s;

   typedef struct packed {
      logic valid;
      vasd_kind_e kind;
      vasd_seg_e segment;
      logic mapped;
      logic cached;
      logic fault;
      vasd_cause_e cause;
      logic [63:0] eff_addr;
      logic [27:0] virtual_page_number;
      logic [15:0] page_offset;
      logic [39:0] paddr;
   } vasd_resp_s;

   typedef struct packed {
      vasd_resp_s resp;
      logic [63:0] bad_vaddr;
      logic [63:0] exc_vector;
   } vasd_state_s;

endpackage

`default_nettype wire

/* File: test/vasd_decoder_sva.sv */
`default_nettype none
module vasd_decoder_sva #(
   parameter int PAGE_SHIFT_64 = 14,
   parameter logic [31:0] EXC_ENTRY = 32'h8000_0000
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire vasd_pkg::vasd_req_s req_in,
   input wire vasd_pkg::vasd_resp_s resp_out,
   input wire logic [63:0] bad_vaddr_out,
   input wire logic [63:0] exc_vector_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import vasd_pkg::*;
   logic [63:0] va;
   logic go;
   logic k32;
   logic k64;
   // Request qualifiers; reset cycles never count as requests
   assign va = req_in.vaddr;
   assign go = req_in.valid && !rst_in;
   assign k32 = go && !req_in.mode64;
   assign k64 = go && req_in.mode64 && !req_in.addr32_op;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   AST_USER32: assert property (k32 && !va[31] |=> resp_out.mapped
      && resp_out.virtual_page_number == {9'h0, $past(va[30:12])})
      else $error("user page number wrong");
   AST_KMAP32: assert property (k32 && !req_in.user_mode
      && va[31:30] == 2'b11 |=> resp_out.mapped
      && resp_out.virtual_page_number == {10'h0, $past(va[29:12])})
      else $error("kernel page number wrong");
   AST_PRIV32: assert property (k32 && req_in.user_mode && va[31]
      |=> resp_out.cause == VASD_CAUSE_PRIVILEGE
      && bad_vaddr_out == {32'h0, $past(va[31:0])})
      else $error("user access to kernel half not refused");
   AST_CACHED32: assert property (k32 && !req_in.user_mode
      && va[31:29] == 3'b100 |=> resp_out.cached && !resp_out.mapped
      && resp_out.paddr == {11'h0, $past(va[28:0])})
      else $error("cached unmapped access wrong");
   AST_UNC32: assert property (k32 && !req_in.user_mode
      && va[31:29] == 3'b101 |=> !resp_out.cached && !resp_out.mapped
      && resp_out.paddr == {11'h0, $past(va[28:0])})
      else $error("uncached unmapped access wrong");
   AST_UNDEF64: assert property (k64 && va[63:62] == 2'b01
      |=> resp_out.fault && resp_out.cause == VASD_CAUSE_UNDEFINED)
      else $error("undefined segment not refused");
   AST_RSV64: assert property (k64 && !req_in.user_mode
      && va[63] == va[62] && va[61:40] != 22'h0
      |=> resp_out.cause == VASD_CAUSE_RESERVED_BITS)
      else $error("nonzero middle bits not refused");
   AST_USER64: assert property (k64 && va[63:40] == 24'h0
      |=> resp_out.mapped && resp_out.virtual_page_number
      == 28'($past(va[39:0]) >> PAGE_SHIFT_64))
      else $error("64-bit user page number wrong");
   AST_KMAP64: assert property (k64 && va[63:40] == 24'hc00000
      |=> resp_out.fault == $past(req_in.user_mode)
      && resp_out.cached == !$past(req_in.user_mode))
      else $error("64-bit kernel mapped access wrong");
   AST_SEXT: assert property (go && req_in.mode64 && req_in.addr32_op
      |=> resp_out.eff_addr == {{32{$past(va[31])}}, $past(va[31:0])})
      else $error("32-bit operand not sign-extended");
   AST_VECTOR: assert property (exc_vector_out[31:29] == 3'b100
      && exc_vector_out == {{32{EXC_ENTRY[31]}}, EXC_ENTRY})
      else $error("exception entry outside cached unmapped segment");
   AST_PHYS64: assert property (k64 && !req_in.user_mode
      && va[63:62] == 2'b10 && va[57:40] == 18'h0
      |=> resp_out.segment == VASD_SEG_PHYS_WINDOW && !resp_out.mapped
      && resp_out.paddr == $past(va[39:0]))
      else $error("physical window access wrong");
endmodule
bind vasd_decoder vasd_decoder_sva #(.PAGE_SHIFT_64(PAGE_SHIFT_64),
   .EXC_ENTRY(EXC_ENTRY)) vasd_decoder_sva_i (.core_clk_in(core_clk_in),
   .rst_in(rst_in), .req_in(req_in), .resp_out(resp_out),
   .bad_vaddr_out(bad_vaddr_out), .exc_vector_out(exc_vector_out));
`default_nettype wire

/* File: test/vasd_pipe_model.sv */
`default_nettype none
module vasd_pipe_model (
   input wire logic core_clk_in,
   output var vasd_pkg::vasd_req_s req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import vasd_pkg::*;
   initial req_out = '0;
   // One request a cycle, launched on the falling edge
   task automatic issue(input logic [63:0] va, input logic m64,
      input logic usr, input logic a32);
      @(negedge core_clk_in);
      req_out = '{valid: 1'b1, vaddr: va, mode64: m64, user_mode: usr,
         addr32_op: a32, kind: VASD_KIND_STORE};
      @(posedge core_clk_in);
      #1;
   endtask
   // Idle address is scrambled so a stale value cannot pass
   task automatic idle();
      @(negedge core_clk_in);
      req_out.valid = 1'b0;
      req_out.vaddr = ~req_out.vaddr;
   endtask
endmodule
`default_nettype wire

/* File: test/vasd_decoder_tb_top.sv */
`default_nettype none
module vasd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import vasd_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   vasd_req_s req_in;
   vasd_resp_s resp_out;
   logic [63:0] bad_vaddr_out;
   logic [63:0] exc_vector_out;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   initial
   begin
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   vasd_decoder vasd_decoder_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .req_in(req_in), .resp_out(resp_out), .bad_vaddr_out(bad_vaddr_out),
      .exc_vector_out(exc_vector_out));
   vasd_pipe_model vasd_pipe_model_i (.core_clk_in(core_clk_in),
      .req_out(req_in));
   task automatic chk(input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rq(input logic [63:0] va, input logic m, u, a);
      vasd_pipe_model_i.issue(va, m, u, a);
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Reset values, also after a reset in mid-run
   task automatic t_reset();
      chk(64'hffff_ffff_8000_0000, exc_vector_out);
      chk(64'h0, bad_vaddr_out);
      chk(VASD_SEG_NONE, resp_out.segment);
   endtask
   // 32-bit segments, back to back, boundary page numbers
   task automatic t_seg32();
      rq(64'ha000_1234, 0, 0, 0);
      chk(VASD_SEG_UNCACHED_UNMAPPED, resp_out.segment);
      chk(64'h1234, resp_out.paddr);
      chk(1'b1, resp_out.valid);
      chk(VASD_KIND_STORE, resp_out.kind);
      rq(64'h8abc_def0, 0, 0, 0);
      chk(2'b01, {resp_out.mapped, resp_out.cached});
      chk(64'h0abc_def0, resp_out.paddr);
      rq(64'h7fff_f5a5, 0, 0, 0);
      chk(64'h7ffff, resp_out.virtual_page_number);
      chk(64'h5a5, resp_out.page_offset);
      rq(64'hffff_f000, 0, 0, 0);
      chk(VASD_SEG_KERNEL_MAPPED, resp_out.segment);
      chk(64'h3ffff, resp_out.virtual_page_number);
   endtask
   // User mode refused above bit 31; fault address stands
   task automatic t_priv();
      rq(64'h8000_0000, 0, 1, 0);
      chk(VASD_CAUSE_PRIVILEGE, resp_out.cause);
      chk(64'h8000_0000, bad_vaddr_out);
      rq(64'hc000_0000, 0, 1, 0);
      chk(1'b1, resp_out.fault);
      rq(64'h0000_1000, 0, 1, 0);
      chk(1'b0, resp_out.fault);
      chk(64'hc000_0000, bad_vaddr_out);
   endtask
   // Idle cycle after a user request whose inverse would fault
   task automatic t_idle();
      vasd_pipe_model_i.idle();
      @(posedge core_clk_in);
      #1;
      chk(1'b0, resp_out.valid);
      chk(1'b0, resp_out.fault);
      chk(64'hc000_0000, bad_vaddr_out);
   endtask
   // 64-bit major segments and refusals
   task automatic t_seg64();
      rq(64'h4000_0000_0000_0000, 1, 0, 0);
      chk(VASD_CAUSE_UNDEFINED, resp_out.cause);
      rq(64'hc000_0000_0000_5000, 1, 1, 0);
      chk(VASD_CAUSE_PRIVILEGE, resp_out.cause);
      rq(64'hc000_00ff_ffff_c000, 1, 0, 0);
      chk(2'b11, {resp_out.mapped, resp_out.cached});
      chk(64'h3ffffff, resp_out.virtual_page_number);
      rq(64'hc000_0100_0000_0000, 1, 0, 0);
      chk(VASD_CAUSE_RESERVED_BITS, resp_out.cause);
      rq(64'h0000_00ff_ffff_c123, 1, 1, 0);
      chk(VASD_SEG_USER, resp_out.segment);
      chk(64'h3ffffff, resp_out.virtual_page_number);
      chk(64'h0123, resp_out.page_offset);
      rq(64'h9000_00ab_cdef_0000, 1, 0, 0);
      chk(VASD_SEG_PHYS_WINDOW, resp_out.segment);
      chk(64'hab_cdef_0000, resp_out.paddr);
      chk(1'b0, resp_out.cached);
      rq(64'hb000_0012_3456_7890, 1, 0, 0);
      chk(1'b1, resp_out.cached);
      chk(64'h12_3456_7890, resp_out.paddr);
      rq(64'hb800_0000_0000_0100, 1, 0, 0);
      chk(1'b0, resp_out.cached);
      rq(64'hb800_0000_0000_0100, 1, 1, 0);
      chk(VASD_CAUSE_PRIVILEGE, resp_out.cause);
      rq(64'h8000_0100_0000_0000, 1, 0, 0);
      chk(VASD_CAUSE_RESERVED_BITS, resp_out.cause);
      rq(64'h1000_0000_0000_0000, 1, 1, 0);
      chk(VASD_CAUSE_RESERVED_BITS, resp_out.cause);
   endtask
   // 32-bit operands in 64-bit mode
   task automatic t_sext();
      rq(64'h5555_5555_8000_0010, 1, 0, 1);
      chk(64'hffff_ffff_8000_0010, resp_out.eff_addr);
      chk(VASD_CAUSE_RESERVED_BITS, resp_out.cause);
      rq(64'haaaa_aaaa_0000_2000, 1, 1, 1);
      chk(64'h2000, resp_out.eff_addr);
      chk(VASD_SEG_USER, resp_out.segment);
   endtask
   // Bounded run in case the handshake hangs
   always @(posedge core_clk_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         results();
      end
   end
   initial
   begin
      repeat (12) @(negedge core_clk_in);
      rst_in = 1'b0;
      t_reset();
      t_seg32();
      t_priv();
      t_idle();
      t_seg64();
      t_sext();
      vasd_pipe_model_i.idle();
      rst_in = 1'b1;
      @(negedge core_clk_in);
      rst_in = 1'b0;
      t_reset();
      rq(64'ha000_1234, 0, 0, 0);
      chk(VASD_SEG_UNCACHED_UNMAPPED, resp_out.segment);
      results();
   end
endmodule
`default_nettype wire
